// File: rccr_pkg.sv
// Package with register map, field layout, reset values and timing counts of the regulator control registers.
package rccr_pkg;

    // Register offsets.
    localparam logic [7:0] ADDR_CHANNEL_ENABLE_CTRL    = 8'h01;
    localparam logic [7:0] ADDR_CH1_VOLTAGE_SELECT     = 8'h02;
    localparam logic [7:0] ADDR_CH2_CH3_VOLTAGE_SELECT = 8'h03;
    localparam logic [7:0] ADDR_CH4_VOLTAGE_SELECT     = 8'h04;
    localparam logic [7:0] ADDR_VOLTAGE_SCALING_CONFIG = 8'h05;

    // Field layout.
    localparam int NUM_CHANNELS   = 5;
    localparam int CH1_CODE_LSB   = 0;
    localparam int CH2_CODE_LSB   = 0;
    localparam int CH3_CODE_LSB   = 4;
    localparam int CH4_CODE_LSB   = 0;
    localparam int CH1_INTVL_LSB  = 0;
    localparam int CH1_SCALE_BIT  = 2;
    localparam int CH4_INTVL_LSB  = 4;
    localparam int CH4_SCALE_BIT  = 6;

    // Reset values.
    localparam logic [7:0] RST_CHANNEL_ENABLE_CTRL    = 8'h1F;
    localparam logic [7:0] RST_VOLTAGE_SELECT         = 8'h00;
    localparam logic [7:0] RST_VOLTAGE_SCALING_CONFIG = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED             = 8'h00;

    // Write masks: storage bits of the channel 1 and channel 4 voltage select registers.
    localparam logic [7:0] MASK_CH1_VOLTAGE_SELECT = 8'h1F;
    localparam logic [7:0] MASK_CH4_VOLTAGE_SELECT = 8'h1F;

    // Scaling step intervals in ns and in clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP0_NS      = 62500;
    localparam int STEP1_NS      = 31200;
    localparam int STEP2_NS      = 15600;
    localparam int STEP3_NS      = 7800;
    localparam logic [12:0] STEP0_CYC = 13'(STEP0_NS / CLK_PERIOD_NS);
    localparam logic [12:0] STEP1_CYC = 13'(STEP1_NS / CLK_PERIOD_NS);
    localparam logic [12:0] STEP2_CYC = 13'(STEP2_NS / CLK_PERIOD_NS);
    localparam logic [12:0] STEP3_CYC = 13'(STEP3_NS / CLK_PERIOD_NS);

    // Stepper states.
    typedef enum logic [1:0] {
        STEP_IDLE = 2'b01,
        STEP_RAMP = 2'b10
    } rccr_step_e;

endpackage

// File: rccr_step_if.sv
// Interface between the register bank and one voltage scaling stepper.
`timescale 1ns/100ps
interface rccr_step_if;
    logic [4:0] code;
    logic       scale_en;
    logic [1:0] interval;
    logic [4:0] target;

    modport ctrl (output code, output scale_en, output interval, input target);
    modport step (input code, input scale_en, input interval, output target);
endinterface

// File: rccr_stepper.sv
// Voltage scaling stepper that walks a target code toward the programmed code.
`timescale 1ns/100ps
module rccr_stepper
    import rccr_pkg::*;
#(
    parameter logic [12:0] CYC0 = rccr_pkg::STEP0_CYC
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    rccr_step_if.step  sif
);
    rccr_step_e  state_q, state_d;
    logic [12:0] cnt_q, cnt_d;
    logic [4:0]  tgt_q, tgt_d;
    logic [12:0] limit;

    // Next state: direct follow when scaling is off, one code per interval when on.
    always_comb begin
        unique case (sif.interval)
            2'b00: limit = CYC0;
            2'b01: limit = STEP1_CYC;
            2'b10: limit = STEP2_CYC;
            2'b11: limit = STEP3_CYC;
        endcase
        state_d = state_q;
        cnt_d   = cnt_q;
        tgt_d   = tgt_q;
        if (!sif.scale_en) begin
            state_d = STEP_IDLE;
            cnt_d   = 13'h0000;
            tgt_d   = sif.code;
        end else begin
            unique case (state_q)
                STEP_IDLE: begin
                    cnt_d = 13'h0000;
                    if (tgt_q != sif.code) begin
                        state_d = STEP_RAMP;
                    end
                end
                STEP_RAMP: begin
                    if (tgt_q == sif.code) begin
                        state_d = STEP_IDLE;
                        cnt_d   = 13'h0000;
                    end else if (cnt_q >= limit - 13'h0001) begin
                        cnt_d = 13'h0000;
                        tgt_d = (tgt_q < sif.code) ? tgt_q + 5'h01 : tgt_q - 5'h01;
                    end else begin
                        cnt_d = cnt_q + 13'h0001;
                    end
                end
                default: begin
                    state_d = STEP_IDLE;
                end
            endcase
        end
    end

    // Stepper registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= STEP_IDLE;
            cnt_q   <= 13'h0000;
            tgt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            tgt_q   <= tgt_d;
        end
    end

    assign sif.target = tgt_q;
endmodule

// File: rccr_top.sv
// Channel enable, voltage select and voltage scaling registers of a multi-channel regulator.
//
// Operation
// - A channel runs only when its software enable bit AND its enable pin are high.
// - Every channel enable bit resets to one.
// - Host writes to an enable bit only land while that channel's pin is high.
// - A low enable pin forces that channel's enable bit back to one.
// - Enable register holds channels 1 to 5 in bits 0 to 4; bits 7:5 read/write.
// - Channel 1 code is five bits 4:0, loaded from fuses at power-up.
// - Channel 1 code zero means adjustable mode; other codes pick fixed voltages.
// - Channel 3 code sits in bits 6:4 of the shared register, fuse default.
// - Channel 2 code sits in bits 2:0 of the shared register, fuse default.
// - Channel 4 code is five bits 4:0; zero adjustable, else 2.4 V plus steps.
// - Scaling config bit 6 enables channel 4 voltage scaling, default off.
// - Bits 5:4 pick channel 4 step interval: 62.5, 31.2, 15.6 or 7.8 us.
// - Scaling config bit 2 enables channel 1 voltage scaling, default off.
// - Bits 1:0 pick channel 1 step interval with the same encoding.
// - Registers return to defaults only under the power-on reset, enable bits 4:0 also while their pin is low.
`timescale 1ns/100ps
module rccr_top
    import rccr_pkg::*;
#(
    parameter logic [12:0] STEP0_CYCLES = rccr_pkg::STEP0_CYC
) (
    input  wire logic       CLOCK,
    input  wire logic       RSTN,
    input  wire logic [4:0] CHANNEL_HW_ENABLE_PIN,
    input  wire logic [7:0] FUSE_CH1_VOLTAGE_SELECT,
    input  wire logic [7:0] FUSE_CH2_CH3_VOLTAGE_SELECT,
    input  wire logic [7:0] FUSE_CH4_VOLTAGE_SELECT,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic      [4:0] CHANNEL_RUN,
    output logic      [4:0] CH1_TARGET_CODE,
    output logic      [2:0] CH2_VOLTAGE_CODE,
    output logic      [2:0] CH3_VOLTAGE_CODE,
    output logic      [4:0] CH4_TARGET_CODE
);
    import rccr_pkg::*;

    logic [7:0] en_ctrl_q,  en_ctrl_d;
    logic [7:0] vsel1_q,    vsel1_d;
    logic [7:0] vsel23_q,   vsel23_d;
    logic [7:0] vsel4_q,    vsel4_d;
    logic [7:0] scale_q,    scale_d;
    logic       loaded_q,   loaded_d;
    logic [7:0] rdata_q,    rdata_d;
    logic [4:0] run_q,      run_d;
    logic [2:0] ch2_q,      ch2_d;
    logic [2:0] ch3_q,      ch3_d;
    logic [4:0] tgt1_q,     tgt1_d;
    logic [4:0] tgt4_q,     tgt4_d;
    logic       wr_en, wr_v1, wr_v23, wr_v4, wr_sc;

    rccr_step_if ch1_if ();
    rccr_step_if ch4_if ();

    // Address decode of host writes.
    assign wr_en  = REG_WR && (REG_ADDR == ADDR_CHANNEL_ENABLE_CTRL);
    assign wr_v1  = REG_WR && (REG_ADDR == ADDR_CH1_VOLTAGE_SELECT);
    assign wr_v23 = REG_WR && (REG_ADDR == ADDR_CH2_CH3_VOLTAGE_SELECT);
    assign wr_v4  = REG_WR && (REG_ADDR == ADDR_CH4_VOLTAGE_SELECT);
    assign wr_sc  = REG_WR && (REG_ADDR == ADDR_VOLTAGE_SCALING_CONFIG);

    // Channel enable register: pin low forces one, writes land only while the pin is high.
    always_comb begin
        en_ctrl_d = en_ctrl_q;
        if (wr_en) begin
            en_ctrl_d[7:NUM_CHANNELS] = REG_WDATA[7:NUM_CHANNELS];
        end
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (!CHANNEL_HW_ENABLE_PIN[i]) begin
                en_ctrl_d[i] = 1'b1;
            end else if (wr_en) begin
                en_ctrl_d[i] = REG_WDATA[i];
            end
        end
    end

    // Voltage select registers: fuse values load once in the first cycle after reset.
    always_comb begin
        loaded_d = 1'b1;
        vsel1_d  = vsel1_q;
        vsel23_d = vsel23_q;
        vsel4_d  = vsel4_q;
        if (!loaded_q) begin
            vsel1_d  = FUSE_CH1_VOLTAGE_SELECT & MASK_CH1_VOLTAGE_SELECT;
            vsel23_d = FUSE_CH2_CH3_VOLTAGE_SELECT;
            vsel4_d  = FUSE_CH4_VOLTAGE_SELECT & MASK_CH4_VOLTAGE_SELECT;
        end else begin
            if (wr_v1) begin
                vsel1_d = REG_WDATA & MASK_CH1_VOLTAGE_SELECT;
            end
            if (wr_v23) begin
                vsel23_d = REG_WDATA;
            end
            if (wr_v4) begin
                vsel4_d = REG_WDATA & MASK_CH4_VOLTAGE_SELECT;
            end
        end
    end

    // Scaling configuration register.
    always_comb begin
        scale_d = scale_q;
        if (wr_sc) begin
            scale_d = REG_WDATA;
        end
    end

    // Read data: mapped registers answer the next cycle, other addresses read zero.
    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_CHANNEL_ENABLE_CTRL:    rdata_d = en_ctrl_q;
                ADDR_CH1_VOLTAGE_SELECT:     rdata_d = vsel1_q;
                ADDR_CH2_CH3_VOLTAGE_SELECT: rdata_d = vsel23_q;
                ADDR_CH4_VOLTAGE_SELECT:     rdata_d = vsel4_q;
                ADDR_VOLTAGE_SCALING_CONFIG: rdata_d = scale_q;
                default:                     rdata_d = RDATA_UNMAPPED;
            endcase
        end
    end

    // Stepper controls for channels 1 and 4.
    assign ch1_if.code     = vsel1_q[CH1_CODE_LSB +: 5];
    assign ch1_if.scale_en = scale_q[CH1_SCALE_BIT];
    assign ch1_if.interval = scale_q[CH1_INTVL_LSB +: 2];
    assign ch4_if.code     = vsel4_q[CH4_CODE_LSB +: 5];
    assign ch4_if.scale_en = scale_q[CH4_SCALE_BIT];
    assign ch4_if.interval = scale_q[CH4_INTVL_LSB +: 2];

    rccr_stepper #(
        .CYC0  (STEP0_CYCLES)
    ) u_step_ch1 (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .sif   (ch1_if)
    );

    rccr_stepper #(
        .CYC0  (STEP0_CYCLES)
    ) u_step_ch4 (
        .clk   (CLOCK),
        .rst_n (RSTN),
        .sif   (ch4_if)
    );

    // Output stage: run enables and voltage codes go out from flip-flops.
    always_comb begin
        run_d  = en_ctrl_q[NUM_CHANNELS-1:0] & CHANNEL_HW_ENABLE_PIN;
        ch2_d  = vsel23_q[CH2_CODE_LSB +: 3];
        ch3_d  = vsel23_q[CH3_CODE_LSB +: 3];
        tgt1_d = ch1_if.target;
        tgt4_d = ch4_if.target;
    end

    // All registers take their reset values under the power-on reset; a low pin also sets that channel's enable bit to one.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            en_ctrl_q <= RST_CHANNEL_ENABLE_CTRL;
            vsel1_q   <= RST_VOLTAGE_SELECT;
            vsel23_q  <= RST_VOLTAGE_SELECT;
            vsel4_q   <= RST_VOLTAGE_SELECT;
            scale_q   <= RST_VOLTAGE_SCALING_CONFIG;
            loaded_q  <= 1'b0;
            rdata_q   <= RDATA_UNMAPPED;
            run_q     <= 5'h00;
            ch2_q     <= 3'h0;
            ch3_q     <= 3'h0;
            tgt1_q    <= 5'h00;
            tgt4_q    <= 5'h00;
        end else begin
            en_ctrl_q <= en_ctrl_d;
            vsel1_q   <= vsel1_d;
            vsel23_q  <= vsel23_d;
            vsel4_q   <= vsel4_d;
            scale_q   <= scale_d;
            loaded_q  <= loaded_d;
            rdata_q   <= rdata_d;
            run_q     <= run_d;
            ch2_q     <= ch2_d;
            ch3_q     <= ch3_d;
            tgt1_q    <= tgt1_d;
            tgt4_q    <= tgt4_d;
        end
    end

    assign REG_RDATA        = rdata_q;
    assign CHANNEL_RUN      = run_q;
    assign CH1_TARGET_CODE  = tgt1_q;
    assign CH2_VOLTAGE_CODE = ch2_q;
    assign CH3_VOLTAGE_CODE = ch3_q;
    assign CH4_TARGET_CODE  = tgt4_q;
endmodule

// File: rccr_checker.sv
// Port checks of the regulator control registers.
`timescale 1ns/100ps
module rccr_checker (
    input wire logic       CLOCK,
    input wire logic       RSTN,
    input wire logic [4:0] CHANNEL_HW_ENABLE_PIN,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [4:0] CHANNEL_RUN,
    input wire logic [4:0] CH1_TARGET_CODE,
    input wire logic [2:0] CH2_VOLTAGE_CODE,
    input wire logic [2:0] CH3_VOLTAGE_CODE,
    input wire logic [4:0] CH4_TARGET_CODE
);
    logic [1:0] scale_on_q;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // Mirrors the two scaling enable bits as the host writes them.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            scale_on_q <= 2'b00;
        end else if (REG_WR && REG_ADDR == 8'h05) begin
            scale_on_q <= {REG_WDATA[6], REG_WDATA[2]};
        end
    end
    run_gated_a: assert property ((CHANNEL_RUN & ~$past(CHANNEL_HW_ENABLE_PIN)) == 5'h00)
        else $error("channel runs with its pin low");
    pin_restart_a: assert property ($rose(CHANNEL_HW_ENABLE_PIN[0]) |=> CHANNEL_RUN[0])
        else $error("no restart after pin rise");
    enable_readback_a: assert property ((REG_WR && REG_ADDR == 8'h01 && CHANNEL_HW_ENABLE_PIN == 5'h1F)
        ##1 (!REG_WR && CHANNEL_HW_ENABLE_PIN == 5'h1F) ##1 (REG_RD && !REG_WR && REG_ADDR == 8'h01)
        |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("enable register readback wrong");
    unmapped_read_a: assert property (REG_RD && (REG_ADDR == 8'h00 || REG_ADDR > 8'h05) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    shared_code_a: assert property ($past(RSTN) && REG_WR && REG_ADDR == 8'h03 |-> ##2
        CH2_VOLTAGE_CODE == $past(REG_WDATA[2:0], 2) && CH3_VOLTAGE_CODE == $past(REG_WDATA[6:4], 2))
        else $error("shared register codes wrong");
    ch1_direct_a: assert property ($past(RSTN) && REG_WR && REG_ADDR == 8'h02 && !scale_on_q[0]
        |-> ##3 CH1_TARGET_CODE == $past(REG_WDATA[4:0], 3)) else $error("channel 1 code not applied");
    ch4_step_a: assert property (scale_on_q[1] [*4] |=>
        5'(CH4_TARGET_CODE - $past(CH4_TARGET_CODE)) inside {5'h00, 5'h01, 5'h1F}) else $error("ramp jumped");
    restart_c: cover property ($fell(CHANNEL_HW_ENABLE_PIN[0]));
    ramp_c: cover property (scale_on_q[1] && $changed(CH4_TARGET_CODE));
    unmapped_c: cover property (REG_RD && REG_ADDR == 8'h06);
endmodule
bind rccr_top rccr_checker chk_i (.CLOCK(CLOCK), .RSTN(RSTN), .CHANNEL_HW_ENABLE_PIN(CHANNEL_HW_ENABLE_PIN),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CHANNEL_RUN(CHANNEL_RUN), .CH1_TARGET_CODE(CH1_TARGET_CODE), .CH2_VOLTAGE_CODE(CH2_VOLTAGE_CODE),
    .CH3_VOLTAGE_CODE(CH3_VOLTAGE_CODE), .CH4_TARGET_CODE(CH4_TARGET_CODE));

// File: rccr_host.sv
// Host model that issues register writes and reads.
`timescale 1ns/100ps
module rccr_host (
    input  wire logic       clk,
    output logic            wr = 1'b0,
    output logic            rd = 1'b0,
    output logic      [7:0] addr = 8'h00,
    output logic      [7:0] wdata = 8'h00,
    input  wire logic [7:0] rdata
);
    // Write strobe held for one taking edge, data scrambled afterwards.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // Read strobe for one edge; the registered answer is taken once settled.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
endmodule

// File: tb_top.sv
// Self-checking testbench of the regulator control registers.
`timescale 1ns/100ps
module tb_top;
    import rccr_pkg::*;
    logic       clock = 1'b0;
    logic       rstn = 1'b0;
    logic [4:0] pins = 5'h1F;
    logic       wr, rd;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] run, t1, t4;
    logic [2:0] c2, c3;
    logic [7:0] fuse1 = 8'h00;
    logic [7:0] fuse23 = 8'h00;
    logic [7:0] fuse4 = 8'h00;
    int         fail_count = 0;
    int         num_checks = 0;
    int         cycles = 0;
    // Clock of 10 ns period.
    always #5 clock = ~clock;
    rccr_top #(.STEP0_CYCLES(13'h014)) dut (.CLOCK(clock), .RSTN(rstn), .CHANNEL_HW_ENABLE_PIN(pins),
        .FUSE_CH1_VOLTAGE_SELECT(fuse1), .FUSE_CH2_CH3_VOLTAGE_SELECT(fuse23), .FUSE_CH4_VOLTAGE_SELECT(fuse4),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CHANNEL_RUN(run),
        .CH1_TARGET_CODE(t1), .CH2_VOLTAGE_CODE(c2), .CH3_VOLTAGE_CODE(c3), .CH4_TARGET_CODE(t4));
    rccr_host host (.clk(clock), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    // Power-on reset with a new fuse image presented while reset is held.
    task automatic t_reset(input logic [7:0] f1, input logic [7:0] f23, input logic [7:0] f4);
        @(posedge clock);
        rstn <= 1'b0;
        fuse1 <= f1;
        fuse23 <= f23;
        fuse4 <= f4;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        $display("reset done");
    endtask
    task automatic t_defaults();
        logic [7:0] a[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00, 8'h06};
        logic [7:0] e[7];
        logic [7:0] d;
        e = '{8'h1F, fuse1 & 8'h1F, fuse23, fuse4 & 8'h1F, 8'h00, 8'h00, 8'h00};
        @(negedge clock);
        check("run", 8'(run), 8'h1F);
        check("ch2", 8'(c2), 8'(fuse23[2:0]));
        check("ch3", 8'(c3), 8'(fuse23[6:4]));
        check("ch1", 8'(t1), fuse1 & 8'h1F);
        check("ch4", 8'(t4), fuse4 & 8'h1F);
        foreach (a[i]) begin
            host.read_reg(a[i], d);
            check("reg", d, e[i]);
        end
        $display("defaults done");
    endtask
    task automatic t_enable();
        logic [7:0] d;
        host.write_reg(8'h01, 8'hE0);
        host.read_reg(8'h01, d);
        check("enables", d, 8'hE0);
        check("run off", 8'(run), 8'h00);
        @(posedge clock);
        pins <= 5'h1E;
        host.write_reg(8'h01, 8'hE0);
        host.read_reg(8'h01, d);
        check("forced", d, 8'hE1);
        @(posedge clock);
        pins <= 5'h1F;
        @(posedge clock);
        @(negedge clock);
        check("restart", 8'(run), 8'h01);
        host.write_reg(8'h01, 8'h1F);
        $display("enable done");
    endtask
    task automatic t_codes();
        logic [4:0] k[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1F};
        logic [7:0] d;
        foreach (k[i]) begin
            host.write_reg(8'h02, {3'h7, k[i]});
            host.read_reg(8'h02, d);
            check("ch1 reg", d, 8'(k[i]));
            check("ch1 out", 8'(t1), 8'(k[i]));
            host.write_reg(8'h04, {3'h7, k[i]});
            host.read_reg(8'h04, d);
            check("ch4 reg", d, 8'(k[i]));
            check("ch4 out", 8'(t4), 8'(k[i]));
        end
        for (int i = 0; i < 8; i++) begin
            host.write_reg(8'h03, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
            host.read_reg(8'h03, d);
            check("shared", d, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
            check("ch3 out", 8'(c3), 8'(i));
            check("ch2 out", 8'(c2), 8'(7 - i));
        end
        $display("codes done");
    endtask
    task automatic ramp(input logic [7:0] a, input logic [4:0] c, input int n, input logic [4:0] o);
        host.write_reg(a, {3'h0, c});
        repeat (n + 1) @(posedge clock);
        @(negedge clock);
        check("held", 8'(a == 8'h02 ? t1 : t4), 8'(o));
        @(negedge clock);
        check("step", 8'(a == 8'h02 ? t1 : t4), 8'(c > o ? o + 5'h01 : o - 5'h01));
    endtask
    task automatic t_scale();
        int n[4] = '{20, int'(STEP1_CYC), int'(STEP2_CYC), int'(STEP3_CYC)};
        logic [7:0] d;
        host.write_reg(8'h04, 8'h05);
        for (int i = 0; i < 4; i++) begin
            host.write_reg(8'h05, 8'h40 | 8'(i << 4));
            ramp(8'h04, 5'(6 + i), n[i], 5'(5 + i));
        end
        host.read_reg(8'h05, d);
        check("scaling", d, 8'h70);
        host.write_reg(8'h05, 8'h04);
        ramp(8'h02, 5'h1D, 20, 5'h1F);
        repeat (20) @(posedge clock);
        @(negedge clock);
        check("ch1 end", 8'(t1), 8'h1D);
        host.write_reg(8'h05, 8'h06);
        ramp(8'h02, 5'h1C, int'(STEP2_CYC), 5'h1D);
        $display("scaling done");
    endtask
    // Second reset loads a different fuse image, so the defaults must follow it.
    initial begin
        t_reset(8'hF3, 8'hA5, 8'hFF);
        t_defaults();
        t_enable();
        t_codes();
        t_scale();
        t_reset(8'h2C, 8'h5A, 8'hE7);
        t_defaults();
        finish_test();
    end
    // Cuts a hung run short.
    always @(posedge clock) begin
        cycles++;
        if (cycles > 12000) begin
            fail_count++;
            finish_test();
        end
    end
endmodule
